// *** shift_move_indirect_pkg.sv ***
// Constants and types shared by the shift, move and indirect load datapath
package shift_move_indirect_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_OFS      = 8'h00;
  localparam logic [7:0] WORK_OFS     = 8'h04;
  localparam logic [7:0] STATUS_OFS   = 8'h08;
  localparam logic [7:0] PTR0_OFS     = 8'h0c;
  localparam logic [7:0] PTR1_OFS     = 8'h10;
  localparam logic [7:0] MEM_ADDR_OFS = 8'h14;
  localparam logic [7:0] MEM_DATA_OFS = 8'h18;
  localparam logic [7:0] EADDR_OFS    = 8'h1c;

  // ----------------------------------------------------------------
  // Command word fields
  // ----------------------------------------------------------------
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_DEST_BIT = 2;
  localparam int CMD_FILE_LSB = 4;
  localparam int CMD_SEL_BIT  = 12;
  localparam int CMD_MODE_LSB = 13;
  localparam int CMD_REL_BIT  = 15;
  localparam int CMD_OFFS_LSB = 16;

  localparam logic [1:0] OP_NONE                 = 2'h0;
  localparam logic [1:0] LOGICAL_SHIFT_RIGHT_OP  = 2'h1;
  localparam logic [1:0] FILE_MOVE_OP            = 2'h2;
  localparam logic [1:0] INDIRECT_LOAD_OP        = 2'h3;

  // Pointer mode code values
  localparam logic [1:0] MODE_PRE_INC  = 2'h0;
  localparam logic [1:0] MODE_PRE_DEC  = 2'h1;
  localparam logic [1:0] MODE_POST_INC = 2'h2;
  localparam logic [1:0] MODE_POST_DEC = 2'h3;

  // ----------------------------------------------------------------
  // Status bits, window addresses, reset values
  // ----------------------------------------------------------------
  localparam int STAT_C_BIT = 0;
  localparam int STAT_Z_BIT = 1;

  localparam logic [6:0] WINDOW0_ADDR = 7'h00;
  localparam logic [6:0] WINDOW1_ADDR = 7'h01;

  localparam int MEM_WORDS = 128;

  localparam logic [7:0]  WORK_RST = 8'h00;
  localparam logic [15:0] PTR_RST  = 16'h0000;
  localparam logic        FLAG_RST = 1'b0;

  typedef enum logic {
    ST_IDLE,
    ST_EXEC
  } exec_state_t;

endpackage : shift_move_indirect_pkg

// *** indirect_ptr_calc.sv ***
// Effective address and pointer update for the indirect load
`timescale 1ns/1ns
`default_nettype none

module indirect_ptr_calc
  import shift_move_indirect_pkg::*;
(
  input  wire logic [15:0] ptr,
  input  wire logic [1:0]  pointer_mode_code,
  input  wire logic        rel,
  input  wire logic [5:0]  offs,
  output logic      [15:0] eff_addr,
  output logic      [15:0] next_ptr
);

  logic [15:0] ptr_inc;
  logic [15:0] ptr_dec;
  logic [15:0] offs_ext;

  // 16-bit adders drop the carry, so both bounds wrap
  assign ptr_inc  = ptr + 16'h0001;
  assign ptr_dec  = ptr - 16'h0001;
  assign offs_ext = {{10{offs[5]}}, offs};

  always_comb begin
    eff_addr = ptr;
    next_ptr = ptr;
    if (rel) begin
      eff_addr = ptr + offs_ext;
      next_ptr = ptr;
    end else begin
      unique case (pointer_mode_code)
        MODE_PRE_INC: begin
          eff_addr = ptr_inc;
          next_ptr = ptr_inc;
        end
        MODE_PRE_DEC: begin
          eff_addr = ptr_dec;
          next_ptr = ptr_dec;
        end
        MODE_POST_INC: begin
          eff_addr = ptr;
          next_ptr = ptr_inc;
        end
        MODE_POST_DEC: begin
          eff_addr = ptr;
          next_ptr = ptr_dec;
        end
      endcase
    end
  end

endmodule : indirect_ptr_calc

`default_nettype wire

// *** shift_move_indirect_exec.sv ***
// Shift, file move and indirect load datapath with an APB register port
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none

module shift_move_indirect_exec
  import shift_move_indirect_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    exec_state_t                st;
    logic [1:0]                 op;
    logic                       dest;
    logic [6:0]                 faddr;
    logic                       sel;
    logic [1:0]                 mode;
    logic                       rel;
    logic [5:0]                 offs;
    logic [7:0]                 work;
    logic                       c;
    logic                       z;
    logic [15:0]                ptr0;
    logic [15:0]                ptr1;
    logic [15:0]                eaddr;
    logic [6:0]                 maddr;
    logic                       pready;
    logic                       pslverr;
    logic [31:0]                prdata;
  } state_t;

  state_t      s_ff;
  state_t      nxt_s;

  logic [15:0] sel_ptr;
  logic [15:0] pu_addr;
  logic [15:0] pu_ptr;
  logic [6:0]  fidx;
  logic [7:0]  src;
  logic [7:0]  res;
  logic [7:0]  ld_val;
  logic        acc_req;
  logic        acc_done;
  logic        addr_ok;
  logic [31:0] wv;

  // ----------------------------------------------------------------
  // File storage
  // ----------------------------------------------------------------
  // Kept out of the state word so it can map onto a plain memory
  logic [7:0]  file_mem [MEM_WORDS];
  logic        mem_we;
  logic [6:0]  mem_wa;
  logic [7:0]  mem_wd;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Window registers hold nothing; they redirect to the pointer target
  function automatic logic [6:0] file_index(input logic [6:0]  f,
                                            input logic [15:0] p0,
                                            input logic [15:0] p1);
    logic [6:0] idx;
    idx = f;
    if (f == WINDOW0_ADDR) begin
      idx = p0[6:0];
    end else if (f == WINDOW1_ADDR) begin
      idx = p1[6:0];
    end
    return idx;
  endfunction : file_index

  // Zero test shared by every instruction that sets the zero flag
  function automatic logic is_zero(input logic [7:0] v);
    return (v == 8'h00);
  endfunction : is_zero

  // Command word as software reads it back; unused bits read as zero
  function automatic logic [31:0] cmd_word(input state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[CMD_OP_LSB +: 2]   = s.op;
    w[CMD_DEST_BIT]      = s.dest;
    w[CMD_FILE_LSB +: 7] = s.faddr;
    w[CMD_SEL_BIT]       = s.sel;
    w[CMD_MODE_LSB +: 2] = s.mode;
    w[CMD_REL_BIT]       = s.rel;
    w[CMD_OFFS_LSB +: 6] = s.offs;
    return w;
  endfunction : cmd_word

  // Unstrobed bytes keep whatever is passed in as the old value
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] m;
    m = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return m;
  endfunction : merge_strb

  // The effective address slot is mapped, so writes to it end without error
  function automatic logic known_addr(input logic [7:0] a);
    return (a == CMD_OFS) || (a == WORK_OFS) || (a == STATUS_OFS) ||
           (a == PTR0_OFS) || (a == PTR1_OFS) || (a == MEM_ADDR_OFS) ||
           (a == MEM_DATA_OFS) || (a == EADDR_OFS);
  endfunction : known_addr

  // ----------------------------------------------------------------
  // Pointer arithmetic
  // ----------------------------------------------------------------
  assign sel_ptr = s_ff.sel ? s_ff.ptr1 : s_ff.ptr0;

  indirect_ptr_calc u_ptr_calc (
    .ptr               (sel_ptr),
    .pointer_mode_code (s_ff.mode),
    .rel               (s_ff.rel),
    .offs              (s_ff.offs),
    .eff_addr          (pu_addr),
    .next_ptr          (pu_ptr)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Ready is a flop, so the answering edge is told apart by its old value
  assign acc_req  = psel && penable && !s_ff.pready;
  assign acc_done = psel && penable && s_ff.pready;
  assign addr_ok  = known_addr(paddr);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_s    = s_ff;
    wv       = 32'h0000_0000;
    // One write port: a command and a bus write never share a cycle
    mem_we   = 1'b0;
    mem_wa   = s_ff.maddr;
    mem_wd   = 8'h00;
    fidx     = file_index(s_ff.faddr, s_ff.ptr0, s_ff.ptr1);
    src      = file_mem[fidx];
    res      = {1'b0, src[7:1]};
    // Only the low address bits reach the on-chip file storage
    ld_val   = file_mem[pu_addr[6:0]];

    nxt_s.pready  = 1'b0;
    nxt_s.pslverr = 1'b0;
    nxt_s.prdata  = 32'h0000_0000;

    unique case (s_ff.st)
      ST_IDLE: begin
        // Answer is held back while a command executes
        if (acc_req) begin
          nxt_s.pready  = 1'b1;
          nxt_s.pslverr = !addr_ok;
          if (!pwrite) begin
            unique case (paddr)
              CMD_OFS: begin
                nxt_s.prdata = cmd_word(s_ff);
              end
              WORK_OFS: begin
                nxt_s.prdata[7:0] = s_ff.work;
              end
              STATUS_OFS: begin
                nxt_s.prdata[STAT_C_BIT] = s_ff.c;
                nxt_s.prdata[STAT_Z_BIT] = s_ff.z;
              end
              PTR0_OFS: begin
                nxt_s.prdata[15:0] = s_ff.ptr0;
              end
              PTR1_OFS: begin
                nxt_s.prdata[15:0] = s_ff.ptr1;
              end
              MEM_ADDR_OFS: begin
                nxt_s.prdata[6:0] = s_ff.maddr;
              end
              MEM_DATA_OFS: begin
                nxt_s.prdata[7:0] = file_mem[s_ff.maddr];
              end
              EADDR_OFS: begin
                nxt_s.prdata[15:0] = s_ff.eaddr;
              end
              default: begin
                nxt_s.prdata = 32'h0000_0000;
              end
            endcase
          end
        end

        if (acc_done && pwrite && addr_ok) begin
          unique case (paddr)
            CMD_OFS: begin
              wv = merge_strb(32'h0000_0000, pwdata, pstrb);
              nxt_s.op    = wv[CMD_OP_LSB +: 2];
              nxt_s.dest  = wv[CMD_DEST_BIT];
              nxt_s.faddr = wv[CMD_FILE_LSB +: 7];
              nxt_s.sel   = wv[CMD_SEL_BIT];
              nxt_s.mode  = wv[CMD_MODE_LSB +: 2];
              nxt_s.rel   = wv[CMD_REL_BIT];
              nxt_s.offs  = wv[CMD_OFFS_LSB +: 6];
              if (wv[CMD_OP_LSB +: 2] != OP_NONE) begin
                nxt_s.st = ST_EXEC;
              end
            end
            WORK_OFS: begin
              wv         = merge_strb({24'h00_0000, s_ff.work}, pwdata, pstrb);
              nxt_s.work = wv[7:0];
            end
            STATUS_OFS: begin
              wv      = merge_strb({30'h0000_0000, s_ff.z, s_ff.c}, pwdata, pstrb);
              nxt_s.c = wv[STAT_C_BIT];
              nxt_s.z = wv[STAT_Z_BIT];
            end
            PTR0_OFS: begin
              wv         = merge_strb({16'h0000, s_ff.ptr0}, pwdata, pstrb);
              nxt_s.ptr0 = wv[15:0];
            end
            PTR1_OFS: begin
              wv         = merge_strb({16'h0000, s_ff.ptr1}, pwdata, pstrb);
              nxt_s.ptr1 = wv[15:0];
            end
            MEM_ADDR_OFS: begin
              wv          = merge_strb({25'h000_0000, s_ff.maddr}, pwdata, pstrb);
              nxt_s.maddr = wv[6:0];
            end
            MEM_DATA_OFS: begin
              wv     = merge_strb({24'h00_0000, file_mem[s_ff.maddr]}, pwdata, pstrb);
              mem_we = 1'b1;
              mem_wa = s_ff.maddr;
              mem_wd = wv[7:0];
            end
            default: begin
              wv = 32'h0000_0000;
            end
          endcase
        end
      end

      ST_EXEC: begin
        // Every command finishes in this single cycle
        nxt_s.st = ST_IDLE;
        unique case (s_ff.op)
          LOGICAL_SHIFT_RIGHT_OP: begin
            nxt_s.c = src[0];
            nxt_s.z = is_zero(res);
            if (s_ff.dest) begin
              mem_we = 1'b1;
              mem_wa = fidx;
              mem_wd = res;
            end else begin
              nxt_s.work = res;
            end
          end
          FILE_MOVE_OP: begin
            nxt_s.z = is_zero(src);
            if (s_ff.dest) begin
              mem_we = 1'b1;
              mem_wa = fidx;
              mem_wd = src;
            end else begin
              nxt_s.work = src;
            end
          end
          INDIRECT_LOAD_OP: begin
            nxt_s.eaddr = pu_addr;
            nxt_s.work  = ld_val;
            nxt_s.z     = is_zero(ld_val);
            // Carry is not touched; the pointer step sets no flag
            if (s_ff.sel) begin
              nxt_s.ptr1 = pu_ptr;
            end else begin
              nxt_s.ptr0 = pu_ptr;
            end
          end
          default: begin
            nxt_s.st = ST_IDLE;
          end
        endcase
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Storage is cleared by reset so a first read sees a known zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < MEM_WORDS; i++) begin
        file_mem[i] <= 8'h00;
      end
    end else if (mem_we) begin
      file_mem[mem_wa] <= mem_wd;
    end
  end

  assign pready  = s_ff.pready;
  assign prdata  = s_ff.prdata;
  assign pslverr = s_ff.pslverr;

endmodule : shift_move_indirect_exec

`default_nettype wire

// *** shift_move_indirect_exec_asserts.sv ***
// Port-level assertions for the shift, move and indirect load datapath
`timescale 1ns/1ns
`default_nettype none

module shift_move_indirect_exec_asserts
  import shift_move_indirect_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic acc;
  logic done;
  logic mapped;
  assign acc    = psel && penable;
  assign done   = acc && pready;
  assign mapped = (paddr <= EADDR_OFS) && (paddr[1:0] == 2'h0);

  // ----
  // Bus answer
  // ----
  a_ready_in_access: assert property (pready |-> acc)
    else $error("ready outside access phase");
  a_ready_one_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero while idle");
  a_ready_bounded: assert property (acc && !pready |-> ##[1:2] pready)
    else $error("access not answered in time");
  a_cmd_one_cycle: assert property (done && pwrite && paddr == CMD_OFS &&
    pwdata[1:0] != OP_NONE |=> !pready ##1 !pready)
    else $error("command execution slot wrong");
  a_unmapped_err: assert property (done && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_no_err: assert property (pready && mapped |-> !pslverr)
    else $error("error on mapped access");
  a_ptr_width: assert property (done && !pwrite &&
    (paddr == PTR0_OFS || paddr == PTR1_OFS || paddr == EADDR_OFS) |-> prdata[31:16] == 16'h0)
    else $error("pointer wider than 16 bits");
  a_work_width: assert property (done && !pwrite && paddr == WORK_OFS |->
    $past(prdata, 1) == 32'h0 && prdata[31:8] == 24'h0)
    else $error("work register wider than 8 bits");
endmodule : shift_move_indirect_exec_asserts

bind shift_move_indirect_exec shift_move_indirect_exec_asserts i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
  .pslverr(pslverr));

`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the shift, move and indirect load datapath
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import shift_move_indirect_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr, r, w;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [15:0] ea, np;
  logic [1:0]  st;
  logic [6:0]  f, loc;
  int          err_total, checked;

  shift_move_indirect_exec i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  // ----
  // Bus cycles, held until pready is sampled high
  // ----
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ready is looked at mid-cycle, away from the edge that launches it
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    rd = prdata;
    e = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  task automatic setm(input logic [6:0] a, input logic [7:0] d);
    wr(MEM_ADDR_OFS, 32'(a));
    wr(MEM_DATA_OFS, 32'(d));
  endtask : setm

  function automatic logic [7:0] exp_res(input logic [1:0] op, input logic [7:0] v);
    return (op == LOGICAL_SHIFT_RIGHT_OP) ? {1'b0, v[7:1]} : v;
  endfunction : exp_res

  function automatic logic [15:0] exp_addr(input logic [1:0] m, input logic rl,
                                           input logic [5:0] k, input logic [15:0] p);
    return rl ? p + {{10{k[5]}}, k} : m[1] ? p : m[0] ? p - 16'h1 : p + 16'h1;
  endfunction : exp_addr

  function automatic logic [15:0] exp_ptr(input logic [1:0] m, input logic rl,
                                          input logic [15:0] p);
    return rl ? p : m[0] ? p - 16'h1 : p + 16'h1;
  endfunction : exp_ptr

  // ----
  // Shift and move through a file address or a window
  // ----
  task automatic fileop(input logic [1:0] op, input logic dst, input logic [6:0] fa,
                        input logic [6:0] lc, input logic [7:0] val);
    st = 2'($urandom);
    w = 8'($urandom);
    setm(lc, val);
    if (fa < 7'h2) wr(fa[0] ? PTR1_OFS : PTR0_OFS, 32'({9'($urandom), lc}));
    wr(WORK_OFS, 32'(w));
    wr(STATUS_OFS, 32'(st));
    r = exp_res(op, val);
    wr(CMD_OFS, 32'(op) | (32'(dst) << CMD_DEST_BIT) | (32'(fa) << CMD_FILE_LSB));
    rdchk(WORK_OFS, 32'(dst ? w : r));
    rdchk(MEM_DATA_OFS, 32'(dst ? r : val));
    rdchk(STATUS_OFS, {30'h0, r == 8'h0, (op == LOGICAL_SHIFT_RIGHT_OP) ? val[0] : st[0]});
  endtask : fileop

  // ----
  // Indirect load, expectations from mode and pointer
  // ----
  task automatic ind(input logic s, input logic [1:0] m, input logic rl,
                     input logic [5:0] k, input logic [15:0] p0, input logic [7:0] val);
    st = 2'($urandom);
    ea = exp_addr(m, rl, k, p0);
    np = exp_ptr(m, rl, p0);
    wr(s ? PTR1_OFS : PTR0_OFS, 32'(p0));
    setm(ea[6:0], val);
    wr(STATUS_OFS, 32'(st));
    wr(CMD_OFS, 32'(INDIRECT_LOAD_OP) | (32'(s) << CMD_SEL_BIT) | (32'(m) << CMD_MODE_LSB)
      | (32'(rl) << CMD_REL_BIT) | (32'(k) << CMD_OFFS_LSB));
    rdchk(WORK_OFS, 32'(val));
    rdchk(s ? PTR1_OFS : PTR0_OFS, 32'(np));
    rdchk(EADDR_OFS, 32'(ea));
    rdchk(STATUS_OFS, {30'h0, val == 8'h0, st[0]});
  endtask : ind

  initial begin
    #80000;
    err_total++;
    complete_run();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    pstrb = 4'hf;
    err_total = 0;
    checked = 0;
    void'($urandom(32'h6cd8));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(PTR1_OFS, 32'h0);
    fileop(LOGICAL_SHIFT_RIGHT_OP, 1'b0, 7'h05, 7'h05, 8'h01);
    fileop(FILE_MOVE_OP, 1'b1, 7'h06, 7'h06, 8'h00);
    fileop(LOGICAL_SHIFT_RIGHT_OP, 1'b1, WINDOW1_ADDR, 7'h33, 8'h80);
    for (int i = 0; i < 12; i++) begin
      f = 7'($urandom);
      loc = (f < 7'h2) ? 7'h40 : f;
      fileop(i[0] ? LOGICAL_SHIFT_RIGHT_OP : FILE_MOVE_OP, 1'($urandom), f, loc, 8'($urandom));
    end
    ind(1'b0, MODE_PRE_INC, 1'b0, 6'h0, 16'hffff, 8'h00);
    ind(1'b1, MODE_PRE_DEC, 1'b0, 6'h0, 16'h0000, 8'h5a);
    ind(1'b1, 2'h0, 1'b1, 6'h20, 16'h1000, 8'h11);
    ind(1'b0, 2'h3, 1'b1, 6'h1f, 16'hfff0, 8'h00);
    for (int i = 0; i < 16; i++) begin
      ind(1'($urandom), 2'(i), i >= 12, 6'($urandom), 16'($urandom), 8'($urandom));
    end
    wr(EADDR_OFS, 32'h1234);
    rdchk(EADDR_OFS, 32'(ea));
    xfer(1'b0, 8'h20, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(rd, 32'h0);
    complete_run();
  end
endmodule : tb_top

`default_nettype wire
